// >>> rtl/spcl_pkg.sv
// constants for the strap pin configuration latch
// assumes a single 250 MHz clock and an apb register port
package spcl_pkg;
    // strap vector layout
    localparam int STRAP_W = 17;
    localparam int S_EMI_FILT = 0;
    localparam int S_FLOW_CTRL = 1;
    localparam int S_LINKUP = 2;
    localparam int S_NEG_A = 3;
    localparam int S_NEG_B = 4;
    localparam int S_MGMT_HI = 5;
    localparam int S_MGMT_LO = 6;
    localparam int S_AUTOSTART = 7;
    localparam int S_P6_MODE_HI = 8;
    localparam int S_P6_MODE_LO = 9;
    localparam int S_P6_ROLE = 10;
    localparam int S_P6_SPEED = 11;
    localparam int S_P7_MODE_HI = 12;
    localparam int S_P7_MODE_LO = 13;
    localparam int S_P7_ROLE = 14;
    localparam int S_P7_SPEED = 15;
    localparam int S_INBAND = 16;
    localparam logic [16:0] STRAP_RST = 17'h000ff;
    // register offsets
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] STRAP_OFS = 12'h004;
    localparam logic [11:0] CFG_OFS = 12'h008;
    localparam logic [11:0] PORT_OFS = 12'h00c;
    localparam int CTRL_SOFT_RST = 0;
    localparam int CTRL_START = 1;
    localparam logic CTRL_START_RST = 1'b0;
    // decoded configuration word
    localparam int CFG_W = 14;
    localparam int C_EMI_FILT = 0;
    localparam int C_FLOW_CTRL = 1;
    localparam int C_FAST = 2;
    localparam int C_AUTONEG = 3;
    localparam int C_AUTO_MDIX = 4;
    localparam int C_MDIX = 5;
    localparam int C_FULL_DPX = 6;
    localparam int C_NAND = 7;
    localparam int C_NEG_RSVD = 8;
    localparam int C_MGMT = 9;
    localparam int C_FWD = 11;
    localparam int C_INBAND = 12;
    localparam int C_VALID = 13;
    localparam logic [13:0] CFG_RST = 14'h041a;
    // per port configuration byte
    localparam int P_MODE = 0;
    localparam int P_MAC = 2;
    localparam int P_REF_OUT = 3;
    localparam int P_REF_IN = 4;
    localparam int P_SPD1000 = 5;
    localparam int P_RSVD = 6;
    localparam int P_SPD_BAD = 7;
    localparam logic [7:0] PORT_RST = 8'h20;
    // codes
    localparam logic [1:0] MGMT_MDIO = 2'h0;
    localparam logic [1:0] MGMT_I2C = 2'h1;
    localparam logic [1:0] MGMT_SPI = 2'h2;
    localparam logic [1:0] PMODE_RGMII = 2'h0;
    localparam logic [1:0] PMODE_RMII = 2'h1;
    localparam logic [1:0] PMODE_RSVD = 2'h2;
    localparam logic [1:0] PMODE_MII = 2'h3;
    // software reset hold time
    localparam int CLK_PERIOD_NS = 4;
    localparam int SOFT_RST_NS = 100;
    localparam logic [7:0] SOFT_RST_CYC = 8'((SOFT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage

// >>> rtl/spcl_port_decode.sv
// decodes the mode, clock role and speed straps of one mac port
// assumes latched strap inputs; purely combinational
`timescale 1ns/1ps
module spcl_port_decode (
    // latched straps
    input wire logic [1:0] mode_i,
    input wire logic role_i,
    input wire logic speed_i,
    // decoded byte
    output logic [7:0] cfg_o
);
    logic is_rmii;
    logic is_mii;

    assign is_rmii = (mode_i == spcl_pkg::PMODE_RMII);
    assign is_mii = (mode_i == spcl_pkg::PMODE_MII);

    always_comb begin
        cfg_o = '0;
        cfg_o[spcl_pkg::P_MODE +: 2] = mode_i;
        cfg_o[spcl_pkg::P_RSVD] = (mode_i == spcl_pkg::PMODE_RSVD);
        cfg_o[spcl_pkg::P_MAC] = is_mii & role_i;
        cfg_o[spcl_pkg::P_REF_OUT] = is_rmii & ~role_i;
        cfg_o[spcl_pkg::P_REF_IN] = is_rmii & role_i;
        cfg_o[spcl_pkg::P_SPD1000] = ~speed_i;
        cfg_o[spcl_pkg::P_SPD_BAD] = (is_rmii | is_mii) & ~speed_i;
    end
endmodule

// >>> rtl/spcl_strap_cell.sv
// one shared strap pin: hi-z while held, sample, then normal drive
// assumes capture and drive enable come from the sequencer in the top
`timescale 1ns/1ps
module spcl_strap_cell #(
    parameter logic RST_VAL = 1'b0
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // sequencer
    input wire logic capture_i,
    input wire logic drive_en_i,
    // pin and normal function
    input wire logic pad_i,
    input wire logic func_i,
    output logic strap_o,
    output logic pad_o,
    output logic pad_oe_o
);
    // latched level, only changed at capture
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            strap_o <= RST_VAL;
        end else if (capture_i) begin
            strap_o <= pad_i;
        end
    end

    // output enable stays low until the sequencer releases the pin
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pad_oe_o <= 1'b0;
        end else begin
            pad_oe_o <= drive_en_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pad_o <= 1'b0;
        end else begin
            pad_o <= drive_en_i & func_i;
        end
    end
endmodule

// >>> rtl/spcl_top.sv
// strap pin configuration latch with apb status and control
// assumes pins synchronous to ref_clk_i and board pulls on every strap
//
// Summary of operation
// - strap pins undriven while chip reset held
// - sample strap levels as reset releases
// - pins become driven outputs after reset
// - software reset also resamples the straps
// - emission filter strap 0 enables filtering
// - flow control strap 1 enables flow control
// - linkup strap 0: fast, no negotiation, full duplex
// - normal linkup: negotiation pair decode
// - fast linkup: strap a picks mdi or crossed
// - management select: mdio, i2c, spi
// - autostart off: forward only after start bit
// - port 6 interface mode decode
// - port 6 clock role and reference direction
// - port 6 speed select, board straps 100
// - port 7 interface mode decode
// - port 7 clock role and reference direction
// - port 7 speed select, board straps 100
// - in-band management strap 1 enables it
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module spcl_top (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // shared strap pins
    input wire logic [16:0] strap_pad_i,
    input wire logic [16:0] func_out_i,
    output logic [16:0] strap_pad_o,
    output logic [16:0] strap_pad_oe_o,
    // device wide settings
    output logic emission_filter_en_o,
    output logic flow_ctrl_en_o,
    output logic fast_linkup_o,
    output logic autoneg_en_o,
    output logic auto_mdix_en_o,
    output logic mdix_crossed_o,
    output logic force_full_duplex_o,
    output logic nand_tree_test_o,
    output logic neg_reserved_o,
    output logic [1:0] mgmt_mode_o,
    output logic forward_en_o,
    output logic inband_mgmt_en_o,
    output logic strap_valid_o,
    // mac port settings
    output logic [7:0] p6_cfg_o,
    output logic [7:0] p7_cfg_o
);
    localparam int SOFT_WAIT_MAX = 40;

    typedef enum logic [1:0] {
        ST_SAMPLE,
        ST_RUN,
        ST_SOFT
    } spcl_state_t;

    spcl_state_t st_q;
    logic [7:0] soft_cnt_q;
    logic capture;
    logic drive_en;
    logic soft_req;
    logic [16:0] strap;
    logic [13:0] cfg_q;
    logic [13:0] cfg_d;
    logic [7:0] p6_q;
    logic [7:0] p7_q;
    logic [7:0] p6_d;
    logic [7:0] p7_d;
    logic start_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic access;
    logic take;
    logic hit;
    logic [31:0] rdata;
    logic wr_ctrl;

    // sequencer: sample once after any reset, then drive
    assign capture = (st_q == ST_SAMPLE);
    assign drive_en = (st_q == ST_RUN);

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_q <= ST_SAMPLE;
        end else begin
            unique case (st_q)
                ST_SAMPLE: begin
                    st_q <= ST_RUN;
                end
                ST_RUN: begin
                    if (soft_req) begin
                        st_q <= ST_SOFT;
                    end
                end
                ST_SOFT: begin
                    if (soft_cnt_q == 8'h00) begin
                        st_q <= ST_SAMPLE;
                    end
                end
                default: begin
                    st_q <= ST_SAMPLE;
                end
            endcase
        end
    end

    // software reset holds pins undriven for a fixed time
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            soft_cnt_q <= 8'h00;
        end else if (st_q == ST_RUN && soft_req) begin
            soft_cnt_q <= spcl_pkg::SOFT_RST_CYC;
        end else if (st_q == ST_SOFT && soft_cnt_q != 8'h00) begin
            soft_cnt_q <= soft_cnt_q - 8'h01;
        end
    end

    // one cell per shared strap pin
    for (genvar g = 0; g < spcl_pkg::STRAP_W; g++) begin : g_cell
        spcl_strap_cell #(
            .RST_VAL(spcl_pkg::STRAP_RST[g])
        ) u_cell (
            .clk_i(ref_clk_i),
            .rst_n_i(reset_n_i),
            .capture_i(capture),
            .drive_en_i(drive_en),
            .pad_i(strap_pad_i[g]),
            .func_i(func_out_i[g]),
            .strap_o(strap[g]),
            .pad_o(strap_pad_o[g]),
            .pad_oe_o(strap_pad_oe_o[g])
        );
    end

    // mac port decoders
    spcl_port_decode u_p6 (
        .mode_i({strap[spcl_pkg::S_P6_MODE_HI], strap[spcl_pkg::S_P6_MODE_LO]}),
        .role_i(strap[spcl_pkg::S_P6_ROLE]),
        .speed_i(strap[spcl_pkg::S_P6_SPEED]),
        .cfg_o(p6_d)
    );

    spcl_port_decode u_p7 (
        .mode_i({strap[spcl_pkg::S_P7_MODE_HI], strap[spcl_pkg::S_P7_MODE_LO]}),
        .role_i(strap[spcl_pkg::S_P7_ROLE]),
        .speed_i(strap[spcl_pkg::S_P7_SPEED]),
        .cfg_o(p7_d)
    );

    // device wide decode
    always_comb begin
        logic normal;
        logic [1:0] neg;
        normal = strap[spcl_pkg::S_LINKUP];
        neg = {strap[spcl_pkg::S_NEG_A], strap[spcl_pkg::S_NEG_B]};
        cfg_d = '0;
        cfg_d[spcl_pkg::C_EMI_FILT] = ~strap[spcl_pkg::S_EMI_FILT];
        cfg_d[spcl_pkg::C_FLOW_CTRL] = strap[spcl_pkg::S_FLOW_CTRL];
        cfg_d[spcl_pkg::C_FAST] = ~normal;
        cfg_d[spcl_pkg::C_FULL_DPX] = ~normal;
        cfg_d[spcl_pkg::C_AUTO_MDIX] = normal;
        cfg_d[spcl_pkg::C_AUTONEG] = normal & (neg == 2'h3);
        cfg_d[spcl_pkg::C_NAND] = normal & (neg == 2'h2);
        cfg_d[spcl_pkg::C_NEG_RSVD] = normal & (neg == 2'h0);
        cfg_d[spcl_pkg::C_MDIX] = ~normal & ~strap[spcl_pkg::S_NEG_A];
        if (strap[spcl_pkg::S_MGMT_HI]) begin
            cfg_d[spcl_pkg::C_MGMT +: 2] = spcl_pkg::MGMT_SPI;
        end else if (strap[spcl_pkg::S_MGMT_LO]) begin
            cfg_d[spcl_pkg::C_MGMT +: 2] = spcl_pkg::MGMT_I2C;
        end else begin
            cfg_d[spcl_pkg::C_MGMT +: 2] = spcl_pkg::MGMT_MDIO;
        end
        cfg_d[spcl_pkg::C_FWD] = drive_en & (strap[spcl_pkg::S_AUTOSTART] | start_q);
        cfg_d[spcl_pkg::C_INBAND] = strap[spcl_pkg::S_INBAND];
        cfg_d[spcl_pkg::C_VALID] = drive_en;
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cfg_q <= spcl_pkg::CFG_RST;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            p6_q <= spcl_pkg::PORT_RST;
            p7_q <= spcl_pkg::PORT_RST;
        end else begin
            p6_q <= p6_d;
            p7_q <= p7_d;
        end
    end

    assign emission_filter_en_o = cfg_q[spcl_pkg::C_EMI_FILT];
    assign flow_ctrl_en_o = cfg_q[spcl_pkg::C_FLOW_CTRL];
    assign fast_linkup_o = cfg_q[spcl_pkg::C_FAST];
    assign autoneg_en_o = cfg_q[spcl_pkg::C_AUTONEG];
    assign auto_mdix_en_o = cfg_q[spcl_pkg::C_AUTO_MDIX];
    assign mdix_crossed_o = cfg_q[spcl_pkg::C_MDIX];
    assign force_full_duplex_o = cfg_q[spcl_pkg::C_FULL_DPX];
    assign nand_tree_test_o = cfg_q[spcl_pkg::C_NAND];
    assign neg_reserved_o = cfg_q[spcl_pkg::C_NEG_RSVD];
    assign mgmt_mode_o = cfg_q[spcl_pkg::C_MGMT +: 2];
    assign forward_en_o = cfg_q[spcl_pkg::C_FWD];
    assign inband_mgmt_en_o = cfg_q[spcl_pkg::C_INBAND];
    assign strap_valid_o = cfg_q[spcl_pkg::C_VALID];
    assign p6_cfg_o = p6_q;
    assign p7_cfg_o = p7_q;

    // apb slave, one wait state on every transfer
    assign access = psel_i & penable_i & ~pready_q;
    assign take = psel_i & penable_i & pready_q;
    assign wr_ctrl = take & pwrite_i & pstrb_i[0] & (paddr_i[11:2] == spcl_pkg::CTRL_OFS[11:2]);
    assign soft_req = wr_ctrl & pwdata_i[spcl_pkg::CTRL_SOFT_RST];

    always_comb begin
        hit = 1'b1;
        rdata = '0;
        case (paddr_i[11:2])
            spcl_pkg::CTRL_OFS[11:2]: begin
                rdata[spcl_pkg::CTRL_SOFT_RST] = ~drive_en;
                rdata[spcl_pkg::CTRL_START] = start_q;
            end
            spcl_pkg::STRAP_OFS[11:2]: begin
                rdata[16:0] = strap;
            end
            spcl_pkg::CFG_OFS[11:2]: begin
                rdata[13:0] = cfg_q;
            end
            spcl_pkg::PORT_OFS[11:2]: begin
                rdata[15:0] = {p7_q, p6_q};
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= access;
            pslverr_q <= access & ~hit;
            prdata_q <= (access & ~pwrite_i) ? rdata : 32'h0000_0000;
        end
    end

    // start switch bit, written by software
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            start_q <= spcl_pkg::CTRL_START_RST;
        end else if (wr_ctrl) begin
            start_q <= pwdata_i[spcl_pkg::CTRL_START];
        end
    end

    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;

    // checks, armed one edge after reset release so the release edge starts no attempt
    logic chk_en_q;

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            chk_en_q <= 1'b0;
        end else begin
            chk_en_q <= 1'b1;
        end
    end

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!chk_en_q);

    strap_hiz_a: assert property (
        (st_q != ST_RUN) |=> (strap_pad_oe_o == 17'h00000))
        else $error("strap pin driven before sampling");

    pin_drive_a: assert property (
        capture |=> ##1 (strap_pad_oe_o == 17'h1ffff))
        else $error("strap pins not driven after sampling");

    strap_latch_a: assert property (
        capture |=> (strap == $past(strap_pad_i)))
        else $error("strap level not latched at sampling");

    strap_hold_a: assert property (
        !capture |=> $stable(strap))
        else $error("latched strap changed outside sampling");

    soft_resample_a: assert property (
        (soft_req && st_q == ST_RUN) |=> ##[1:SOFT_WAIT_MAX] capture)
        else $error("software reset did not resample straps");

    emi_decode_a: assert property (
        capture |=> ##1 (emission_filter_en_o == ~$past(strap_pad_i[spcl_pkg::S_EMI_FILT], 2)))
        else $error("emission filter setting wrong");

    flow_decode_a: assert property (
        (st_q == ST_RUN) |=> (flow_ctrl_en_o == $past(strap[spcl_pkg::S_FLOW_CTRL])))
        else $error("flow control setting wrong");

    inband_decode_a: assert property (
        (st_q == ST_RUN) |=> (inband_mgmt_en_o == $past(strap[spcl_pkg::S_INBAND])))
        else $error("in-band management setting wrong");

    mdix_fixed_a: assert property (
        (st_q == ST_RUN && !strap[spcl_pkg::S_LINKUP])
            |=> (mdix_crossed_o == !$past(strap[spcl_pkg::S_NEG_A])))
        else $error("fast linkup pair mapping wrong");

    fast_link_a: assert property (
        fast_linkup_o |-> (!autoneg_en_o && !auto_mdix_en_o && force_full_duplex_o))
        else $error("fast linkup left negotiation enabled");

    mgmt_sel_a: assert property (
        (st_q == ST_RUN && strap[spcl_pkg::S_MGMT_HI]) |=> (mgmt_mode_o == spcl_pkg::MGMT_SPI))
        else $error("management select not spi");

    fwd_gate_a: assert property (
        (!strap[spcl_pkg::S_AUTOSTART] && !start_q) |=> !forward_en_o)
        else $error("forwarding without start bit");

    p6_speed_a: assert property (
        $changed(strap[spcl_pkg::S_P6_SPEED])
            |=> (p6_cfg_o[spcl_pkg::P_SPD1000] != strap[spcl_pkg::S_P6_SPEED]))
        else $error("port 6 speed decode wrong");
endmodule

// >>> testbench/spcl_board_pulls.sv
// board pull resistors on the shared strap pins
// assumes one pull per pin; the device drive wins while its enable is high
`timescale 1ns/1ps
module spcl_board_pulls (
    // pull levels chosen by the bench
    input wire logic [16:0] pull_lvl_i,
    // device side of the pins
    input wire logic [16:0] pad_drv_i,
    input wire logic [16:0] pad_oe_i,
    // resolved wire level
    output logic [16:0] pad_lvl_o
);
    // undriven pins settle to the pull level, never to the last driven value
    assign pad_lvl_o = (pad_oe_i & pad_drv_i) | (~pad_oe_i & pull_lvl_i);
endmodule

// >>> testbench/test_strap_pin_config_latch.sv
// self-checking bench for the strap pin configuration latch
// assumes the board pull model and apb access with one wait state
`timescale 1ns/1ps
module test_strap_pin_config_latch;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [16:0] func_out = 17'h00000;
    logic [16:0] lvl = 17'h000ff;
    logic [16:0] pad_lvl, pad_drv, pad_oe, func_prev;
    logic [31:0] prdata;
    logic pready, pslverr, oe_prev;
    logic emi, flow, fast, aneg, amdix, xover, fdx, nand_t, nrsv, fwd, inb, valid;
    logic [1:0] mgmt;
    logic [7:0] p6, p7;
    logic [32:0] exp_q[$];
    logic [32:0] e;
    logic [16:0] s;
    int err_total = 0;
    int check_count = 0;
    wire [13:0] cfg_pins = {valid, inb, fwd, mgmt, nrsv, nand_t, fdx, xover, amdix, aneg, fast,
        flow, emi};

    spcl_board_pulls board (.pull_lvl_i(lvl), .pad_drv_i(pad_drv), .pad_oe_i(pad_oe),
        .pad_lvl_o(pad_lvl));
    spcl_top dut (.ref_clk_i(ref_clk), .reset_n_i(reset_n), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hf),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .strap_pad_i(pad_lvl),
        .func_out_i(func_out), .strap_pad_o(pad_drv), .strap_pad_oe_o(pad_oe),
        .emission_filter_en_o(emi), .flow_ctrl_en_o(flow), .fast_linkup_o(fast),
        .autoneg_en_o(aneg), .auto_mdix_en_o(amdix), .mdix_crossed_o(xover),
        .force_full_duplex_o(fdx), .nand_tree_test_o(nand_t), .neg_reserved_o(nrsv),
        .mgmt_mode_o(mgmt), .forward_en_o(fwd), .inband_mgmt_en_o(inb),
        .strap_valid_o(valid), .p6_cfg_o(p6), .p7_cfg_o(p7));

    always #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk) func_out <= 17'($urandom);

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic wait_for(input logic want);
        int n;
        n = 0;
        while (valid !== want) begin
            @(posedge ref_clk);
            if (++n > 200) begin
                chk(1'b0, 1'b1);
                end_of_test();
            end
        end
        @(posedge ref_clk);
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
        input logic [32:0] exp);
        int n;
        n = 0;
        exp_q.push_back(exp);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) begin
            @(posedge ref_clk);
            if (++n > 50) begin
                chk(1'b0, 1'b1);
                end_of_test();
            end
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    // results seen on the bus are matched against the oldest note, driven pins against the previous func_out
    always @(posedge ref_clk) begin
        if (pready === 1'b1) begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 33'h1ffffffff;
            chk({pslverr, prdata}, e);
        end
        if (pad_oe === 17'h1ffff && oe_prev === 1'b1) begin
            chk(pad_drv, func_prev);
        end
        oe_prev <= &pad_oe;
        func_prev <= func_out;
    end

    function automatic logic [13:0] exp_cfg(input logic [16:0] v, input logic st);
        logic [13:0] c;
        c = {1'b1, v[16], v[7] | st, 2'h0, v[2] & ~v[3] & ~v[4], v[2] & v[3] & ~v[4], ~v[2],
            ~v[2] & ~v[3], v[2], v[2] & v[3] & v[4], ~v[2], v[1], ~v[0]};
        c[10:9] = v[5] ? spcl_pkg::MGMT_SPI : (v[6] ? spcl_pkg::MGMT_I2C : spcl_pkg::MGMT_MDIO);
        return c;
    endfunction

    function automatic logic [7:0] exp_port(input logic [1:0] m, input logic r, input logic sp);
        return {m[0] & ~sp, m == spcl_pkg::PMODE_RSVD, ~sp, (m == spcl_pkg::PMODE_RMII) & r,
            (m == spcl_pkg::PMODE_RMII) & ~r, (m == spcl_pkg::PMODE_MII) & r, m};
    endfunction

    function automatic logic [16:0] mk(input int i);
        logic [16:0] v;
        v = 17'($urandom);
        v[2] = i[2];
        {v[3], v[4]} = i[1:0];
        {v[5], v[6]} = i[1:0];
        {v[8], v[9]} = i[1:0];
        {v[12], v[13]} = ~i[1:0];
        v[7] = i[0];
        v[11] = v[11] | v[9];
        v[15] = v[15] | v[13];
        return v;
    endfunction

    task automatic check_all(input logic [16:0] v, input logic st);
        logic [15:0] pw;
        pw = {exp_port({v[12], v[13]}, v[14], v[15]), exp_port({v[8], v[9]}, v[10], v[11])};
        chk(cfg_pins, exp_cfg(v, st));
        chk({p7, p6}, pw);
        chk(pad_oe, 17'h1ffff);
        apb(1'b0, spcl_pkg::STRAP_OFS, 32'h0, {16'h0, v});
        apb(1'b0, spcl_pkg::CFG_OFS, 32'h0, {19'h0, exp_cfg(v, st)});
        apb(1'b0, spcl_pkg::PORT_OFS, 32'h0, {17'h0, pw});
    endtask

    initial begin
        void'($urandom(7275));
        for (int i = 0; i < 8; i++) begin
            s = mk(i);
            lvl <= s;
            reset_n <= 1'b0;
            repeat (12) @(posedge ref_clk);
            chk(pad_oe, 17'h00000);
            reset_n <= 1'b1;
            wait_for(1'b1);
            lvl <= ~s;
            check_all(s, 1'b0);
            apb(1'b0, 12'h010, 32'h0, {1'b1, 32'h0});
            apb(1'b1, spcl_pkg::CTRL_OFS, 32'h2, 33'h0);
            repeat (2) @(posedge ref_clk);
            chk(fwd, 1'b1);
            apb(1'b0, spcl_pkg::CTRL_OFS, 32'h0, 33'h2);
            s = mk(7 - i);
            lvl <= s;
            apb(1'b1, spcl_pkg::CTRL_OFS, 32'h3, 33'h0);
            wait_for(1'b0);
            wait_for(1'b1);
            check_all(s, 1'b1);
            $display("test %0d done", i);
        end
        repeat (4) @(posedge ref_clk);
        chk(exp_q.size(), 0);
        end_of_test();
    end
endmodule
